// file: design/dbs_sequencer.sv
/*
  DC braking sequencer: decides when the drive stops normal output,
  coasts, and injects DC braking current, with its registers on an
  Avalon-MM slave. Assumes the run and brake-request pins are
  asynchronous and the frequency words come from logic on clk_i.
*/
// The register addresses and register access over Avalon-MM are this design's own decisions.
// Operation
// - Enable select: off, auto, frequency-triggered
// - Brake when output reaches start frequency
// - Coast for wait time before braking
// - Force zero gives zero, max gives rated
// - Stop duration times edge and internal braking
// - Trigger select: edge or level
// - Start braking for start duration on run
// - Own braking carrier, derate at 3 kHz
// - Function 07 input brakes, stop force
// - Start settings apply in both modes
// - Stop: cut output, wait, then brake
// - Edge mode brakes for full duration
// - Level mode: run ends braking immediately
// - Frequency mode ignores input and auto braking
// - Frequency mode brakes only while running
// - Brake when command and output below start
// - Release at start frequency plus 2 Hz
// - Run with zero command starts braking
// - Run above start frequency starts normally
// - Release path follows edge or level setting; braking begun at run releases at once
module dbs_sequencer #(
  parameter int TICK_COUNT = dbs_pkg::TICK_CYCLES  // cycles per 0.1 s
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Pins and drive words
  input  wire logic        run_cmd_i,       // forward run command
  input  wire logic        brake_req_i,     // brake request input
  input  wire logic [15:0] cmd_freq_i,      // commanded, 0.01 Hz
  input  wire logic [15:0] out_freq_i,      // output, 0.01 Hz
  // Output stage
  output logic             drive_on_o,      // normal output enabled
  output logic             brake_on_o,      // DC braking current on
  output logic [7:0]       brake_pct_o,     // braking current, % rated
  output logic [7:0]       brake_carrier_o, // carrier, 0.1 kHz
  output logic             carrier_derate_o // reduced braking power
);
  import dbs_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dbs_cfg_t    cfg_r;          // settings written by software
  dbs_state_t  st_r;           // sequencer state
  dbs_state_t  st_nxt;
  logic [1:0]  run_sync_r;     // run pin synchroniser
  logic [1:0]  req_sync_r;     // brake pin synchroniser
  logic        run_q_r;        // run, delayed for edges
  logic        req_q_r;        // brake input, delayed
  logic [31:0] tick_cnt_r;     // 0.1 s prescaler
  logic        tick;           // one-cycle 0.1 s strobe
  logic [9:0]  tmr_r;          // remaining 0.1 s units
  logic [9:0]  tmr_nxt;
  logic        tmr_load;       // restart timer this cycle
  logic        use_start_r;    // braking with start settings
  logic        use_start_nxt;
  logic        timed_r;        // braking ends on timer
  logic        timed_nxt;
  logic        ext_r;          // braking requested by input
  logic        ext_nxt;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Merge write data into a field under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Limit a 0.1 s setting to its range
  function automatic logic [9:0] lim10(input logic [9:0] v,
                                       input logic [9:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops each; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_sync_r <= 2'h0;
      req_sync_r <= 2'h0;
      run_q_r    <= 1'b0;
      req_q_r    <= 1'b0;
    end else begin
      run_sync_r <= {run_sync_r[0], run_cmd_i};
      req_sync_r <= {req_sync_r[0], brake_req_i};
      run_q_r    <= run_sync_r[1];
      req_q_r    <= req_sync_r[1];
    end
  end

  // ----------------------------------------
  // Decoded conditions
  // ----------------------------------------
  logic        run;        // synchronised run command
  logic        run_rise;   // run just asserted
  logic        ext_en;     // input terminal brakes the motor
  logic        req;        // synchronised brake request
  logic        req_rise;   // brake request edge
  logic        low_out;    // output at or below start frequency
  logic        low_cmd;    // command at or below start frequency
  logic        cmd_high;   // command at release threshold
  logic [16:0] rel_freq;   // start frequency plus hysteresis

  assign run      = run_sync_r[1];
  assign run_rise = run && !run_q_r;
  assign req      = req_sync_r[1];
  assign req_rise = req && !req_q_r;
  // Terminal brakes in any mode but frequency-triggered
  assign ext_en   = (cfg_r.term_fn == FN_BRAKE) &&
                    (cfg_r.en_sel != EN_FREQ);
  // Comparisons in 0.01 Hz units
  assign low_out  = out_freq_i <= cfg_r.bfreq;
  assign low_cmd  = cmd_freq_i <= cfg_r.bfreq;
  assign rel_freq = {1'b0, cfg_r.bfreq} + {1'b0, FREQ_HYST};
  assign cmd_high = {1'b0, cmd_freq_i} >= rel_freq;

  // ----------------------------------------
  // 0.1 s time base
  // ----------------------------------------
  // Restarted with each timer load so a wait is never short
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || tmr_load) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = tick_cnt_r == 32'(TICK_COUNT - 1);

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    st_nxt         = st_r;
    tmr_load       = 1'b0;
    tmr_nxt        = tmr_r;
    use_start_nxt  = use_start_r;
    timed_nxt      = timed_r;
    ext_nxt        = ext_r;
    unique case (st_r)
      DBS_IDLE: begin
        if (ext_en && (cfg_r.level ? req : req_rise)) begin
          // Input brake from standstill
          st_nxt    = DBS_WAIT;
          tmr_load  = 1'b1;
          tmr_nxt   = lim10(cfg_r.wait_t, WAIT_MAX);
          use_start_nxt = 1'b0;
          timed_nxt = !cfg_r.level;
          ext_nxt   = 1'b1;
        end else if (run_rise && cfg_r.en_sel == EN_AUTO) begin
          // Start braking, same in edge and level
          st_nxt        = DBS_BRAKE;
          tmr_load      = 1'b1;
          tmr_nxt       = lim10(cfg_r.start_dur, DUR_MAX);
          use_start_nxt = 1'b1;
          timed_nxt     = 1'b1;
          ext_nxt       = 1'b0;
        end else if (run_rise && cfg_r.en_sel == EN_FREQ &&
                     low_cmd && low_out) begin
          // Zero command at start: begin in braking
          st_nxt        = DBS_BRAKE;
          use_start_nxt = 1'b0;
          timed_nxt     = 1'b0;
          ext_nxt       = 1'b0;
        end else if (run_rise) begin
          st_nxt = DBS_RUN;
        end
      end
      DBS_RUN: begin
        if (ext_en && (cfg_r.level ? req : req_rise)) begin
          // Input brake overrides running output
          st_nxt    = DBS_WAIT;
          tmr_load  = 1'b1;
          tmr_nxt   = lim10(cfg_r.wait_t, WAIT_MAX);
          use_start_nxt = 1'b0;
          timed_nxt = !cfg_r.level;
          ext_nxt   = 1'b1;
        end else if (cfg_r.en_sel == EN_AUTO && !run && low_out) begin
          // Stop braking at the start frequency
          st_nxt    = DBS_WAIT;
          tmr_load  = 1'b1;
          tmr_nxt   = lim10(cfg_r.wait_t, WAIT_MAX);
          use_start_nxt = 1'b0;
          timed_nxt = 1'b1;
          ext_nxt   = 1'b0;
        end else if (cfg_r.en_sel == EN_FREQ && run &&
                     low_cmd && low_out) begin
          // Both frequencies low while running
          st_nxt    = DBS_WAIT;
          tmr_load  = 1'b1;
          tmr_nxt   = lim10(cfg_r.wait_t, WAIT_MAX);
          use_start_nxt = 1'b0;
          timed_nxt = !cfg_r.level;
          ext_nxt   = 1'b0;
        end else if (!run && out_freq_i == 16'h0) begin
          st_nxt = DBS_IDLE;  // decelerated to rest
        end
      end
      DBS_WAIT: begin
        if (cfg_r.en_sel == EN_FREQ && !ext_r && !run) begin
          st_nxt = DBS_IDLE;
        end else if (cfg_r.level && ext_r && !req) begin
          st_nxt = run ? DBS_RUN : DBS_IDLE;         // request withdrawn
        end else if (tmr_r == 10'h0) begin
          // Coast over, braking begins
          st_nxt   = DBS_BRAKE;
          tmr_load = 1'b1;
          tmr_nxt  = lim10(cfg_r.stop_dur, DUR_MAX);
        end
      end
      DBS_BRAKE: begin
        if (ext_r && cfg_r.level) begin
          // Level input: brake exactly while held
          if (!req) begin
            st_nxt = run ? DBS_RUN : DBS_IDLE;
          end
        end else if (!ext_r && cfg_r.en_sel == EN_FREQ) begin
          if (!run) begin
            st_nxt = DBS_IDLE;
          end else if (cmd_high && (!timed_r || tmr_r == 10'h0)) begin
            // Edge waits out the duration; level, and braking begun at run, leave at once
            st_nxt = DBS_RUN;
          end
        end else if (!use_start_r && cfg_r.level && run &&
                     !ext_r && run_rise) begin
          // Start command cuts braking short
          st_nxt = DBS_RUN;
        end else if (tmr_r == 10'h0) begin
          // Duration spent; new commands waited out
          st_nxt = (run || use_start_r) ? DBS_RUN : DBS_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= DBS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Braking kind
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      use_start_r  <= 1'b0;
      timed_r      <= 1'b0;
      ext_r        <= 1'b0;
    end else begin
      use_start_r  <= use_start_nxt;
      timed_r      <= timed_nxt;
      ext_r        <= ext_nxt;
    end
  end

  // ----------------------------------------
  // Duration timer, 0.1 s units
  // ----------------------------------------
  // Holds at zero; zero settings skip the phase at once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tmr_r <= 10'h0;
    end else if (tmr_load) begin
      tmr_r <= tmr_nxt;
    end else if (tick && tmr_r != 10'h0) begin
      tmr_r <= tmr_r - 10'h1;
    end
  end

  // ----------------------------------------
  // Output stage drive
  // ----------------------------------------
  // Force scaled so the top setting is rated current
  logic [7:0]  force_sel;
  logic [15:0] force_pct;
  logic [7:0]  carr_lim;
  assign force_sel = (st_nxt != DBS_BRAKE) ? 8'h0 :
                     (use_start_nxt ? cfg_r.start_force : cfg_r.stop_force);
  assign force_pct = (16'(force_sel) * 16'(PCT_FULL)) / 16'(FORCE_MAX);
  assign carr_lim  = (cfg_r.carrier < CARR_MIN) ? CARR_MIN :
                     (cfg_r.carrier > CARR_MAX) ? CARR_MAX : cfg_r.carrier;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      drive_on_o       <= 1'b0;
      brake_on_o       <= 1'b0;
      brake_pct_o      <= 8'h0;
      brake_carrier_o  <= CARR_MIN;
      carrier_derate_o <= 1'b0;
    end else begin
      drive_on_o       <= st_nxt == DBS_RUN;
      brake_on_o       <= st_nxt == DBS_BRAKE;
      brake_pct_o      <= force_pct[7:0];
      brake_carrier_o  <= carr_lim;
      carrier_derate_o <= carr_lim >= CARR_DERATE;
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // One wait state: data latched on the same edge that waitrequest drops
  logic        acc;        // request seen this cycle
  logic [31:0] rd_val;     // read mux
  assign acc = (avs_read_i || avs_write_i) && avs_waitrequest_o;

  always_comb begin
    rd_val = 32'h0;  // unmapped reads return zero
    unique case (avs_address_i)
      OFS_CTRL:  rd_val = {16'h0, cfg_r.term_fn, 5'h0, cfg_r.level,
                           cfg_r.en_sel};
      OFS_BFREQ: rd_val = {16'h0, cfg_r.bfreq};
      OFS_WAIT:  rd_val = {22'h0, cfg_r.wait_t};
      OFS_FORCE: rd_val = {16'h0, cfg_r.start_force, cfg_r.stop_force};
      OFS_SDUR:  rd_val = {22'h0, cfg_r.stop_dur};
      OFS_TDUR:  rd_val = {22'h0, cfg_r.start_dur};
      OFS_CARR:  rd_val = {24'h0, cfg_r.carrier};
      OFS_STAT:  rd_val = {12'h0, brake_pct_o, tmr_r, st_r};
      default:   rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else if (acc) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= avs_read_i ? rd_val : 32'h0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  // Writes land on the edge where waitrequest is seen low
  logic [31:0] wm;  // merged write word
  always_comb begin
    wm = be_merge(rd_val, avs_writedata_i, avs_byteenable_i);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= '{en_sel: EN_OFF, level: 1'b0, term_fn: 8'h0,
                 bfreq: 16'h0, wait_t: 10'h0, stop_force: 8'h0,
                 start_force: 8'h0, stop_dur: 10'h0, start_dur: 10'h0,
                 carrier: CARR_MIN};
    end else if (avs_write_i && !avs_waitrequest_o) begin
      unique case (avs_address_i)
        OFS_CTRL: begin
          cfg_r.en_sel  <= (wm[1:0] > EN_FREQ) ? EN_OFF : wm[1:0];
          cfg_r.level   <= wm[2];
          cfg_r.term_fn <= wm[15:8];
        end
        OFS_BFREQ: cfg_r.bfreq <= (wm[15:0] > FREQ_MAX) ? FREQ_MAX : wm[15:0];
        OFS_WAIT:  cfg_r.wait_t <= wm[9:0];
        OFS_FORCE: begin
          cfg_r.stop_force  <= (wm[7:0] > FORCE_MAX) ? FORCE_MAX : wm[7:0];
          cfg_r.start_force <= (wm[15:8] > FORCE_MAX) ? FORCE_MAX : wm[15:8];
        end
        OFS_SDUR:  cfg_r.stop_dur <= wm[9:0];
        OFS_TDUR:  cfg_r.start_dur <= wm[9:0];
        OFS_CARR:  cfg_r.carrier <= wm[7:0];
        default:   cfg_r <= cfg_r;  // read-only or unmapped
      endcase
    end
  end
endmodule // dbs_sequencer

// file: pkg/dbs_pkg.sv
/*
  Shared constants and types of the DC braking sequencer.
  Assumes one 125 MHz clock and a 32-bit Avalon-MM register bus.
*/
package dbs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;           // 125 MHz
  localparam int TICK_NS       = 100_000_000; // 0.1 s time base
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_CTRL   = 6'h00; // mode, trigger, terminal fn
  localparam logic [5:0] OFS_BFREQ  = 6'h04; // start frequency, 0.01 Hz
  localparam logic [5:0] OFS_WAIT   = 6'h08; // wait time, 0.1 s
  localparam logic [5:0] OFS_FORCE  = 6'h0c; // stop [7:0], start [15:8]
  localparam logic [5:0] OFS_SDUR   = 6'h10; // stop duration, 0.1 s
  localparam logic [5:0] OFS_TDUR   = 6'h14; // start duration, 0.1 s
  localparam logic [5:0] OFS_CARR   = 6'h18; // carrier, 0.1 kHz
  localparam logic [5:0] OFS_STAT   = 6'h1c; // read-only status

  // ----------------------------------------
  // Field limits and codes
  // ----------------------------------------
  localparam logic [1:0]  EN_OFF     = 2'h0;   // internal braking off
  localparam logic [1:0]  EN_AUTO    = 2'h1;   // start and stop braking
  localparam logic [1:0]  EN_FREQ    = 2'h2;   // frequency-triggered
  localparam logic [7:0]  FN_BRAKE   = 8'h07;  // terminal function code
  localparam logic [15:0] FREQ_MAX   = 16'h9c40; // 400.00 Hz
  localparam logic [15:0] FREQ_HYST  = 16'h00c8; // 2.00 Hz
  localparam logic [9:0]  WAIT_MAX   = 10'h032;  // 5.0 s
  localparam logic [9:0]  DUR_MAX    = 10'h258;  // 60.0 s
  localparam logic [7:0]  FORCE_MAX  = 8'h46;    // 70 = rated current
  localparam logic [7:0]  PCT_FULL   = 8'h64;    // 100 percent
  localparam logic [7:0]  CARR_MIN   = 8'h05;    // 0.5 kHz
  localparam logic [7:0]  CARR_MAX   = 8'h78;    // 12.0 kHz
  localparam logic [7:0]  CARR_DERATE = 8'h1e;   // 3.0 kHz

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DBS_IDLE  = 2'b00,  // output off, stopped
    DBS_RUN   = 2'b01,  // normal output
    DBS_WAIT  = 2'b10,  // output cut, motor coasts
    DBS_BRAKE = 2'b11   // DC braking current
  } dbs_state_t;

  typedef struct packed {
    logic [1:0]  en_sel;      // internal brake enable select
    logic        level;       // trigger detect: 0 edge, 1 level
    logic [7:0]  term_fn;     // input terminal function select
    logic [15:0] bfreq;       // brake start frequency
    logic [9:0]  wait_t;      // brake wait time
    logic [7:0]  stop_force;  // stop brake force
    logic [7:0]  start_force; // start brake force
    logic [9:0]  stop_dur;    // stop brake duration
    logic [9:0]  start_dur;   // start brake duration
    logic [7:0]  carrier;     // brake carrier frequency
  } dbs_cfg_t;
endpackage

// file: verification/dbs_motor_model.sv
/*
  Motor and output stage: shaft frequency follows the sequencer's levels.
  Assumes drive and brake levels come on the same clock.
*/
module dbs_motor_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Sequencer levels and target
  input  wire logic        drive_on_i,  // Normal output on
  input  wire logic        brake_on_i,  // DC current on
  input  wire logic [15:0] cmd_freq_i,  // Target, 0.01 Hz
  output logic      [15:0] out_freq_o   // Shaft, 0.01 Hz
);
  // Ramp 1 Hz a cycle under drive; DC current stops fast, coasting is slow
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_freq_o <= 16'h0000;
    end else if (drive_on_i) begin
      out_freq_o <= (cmd_freq_i > out_freq_o + 16'h0064) ? out_freq_o + 16'h0064 :
                    (out_freq_o > cmd_freq_i + 16'h0064) ? out_freq_o - 16'h0064 : cmd_freq_i;
    end else begin
      out_freq_o <= (out_freq_o > 16'h0064) ? out_freq_o - (brake_on_i ? 16'h0064 : 16'h000a)
                                            : 16'h0000;
    end
  end
endmodule // dbs_motor_model

// file: verification/dbs_seq_monitor.sv
/*
  Checker of the braking sequencer's output behaviour.
  Sees only the top ports; settings are mirrored from completed bus writes.
*/
module dbs_seq_monitor
  import dbs_pkg::*;
#(
  parameter int TICK_COUNT = 10  // Cycles per 0.1 s
) (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  // Pins and output stage
  input wire logic        run_cmd_i,
  input wire logic [15:0] cmd_freq_i,
  input wire logic [15:0] out_freq_i,
  input wire logic        drive_on_o,
  input wire logic        brake_on_o,
  input wire logic [7:0]  brake_pct_o,
  input wire logic [7:0]  brake_carrier_o,
  input wire logic        carrier_derate_o
);
  logic [31:0] cfg_r [8];  // Mirror; byte lanes ignored, bench writes whole words except one write to the unread force word
  logic [1:0]  mode;
  logic        lvl;
  logic [15:0] bfq;
  logic [9:0]  wt, sd, td;
  logic        slow;       // Tick long enough for 8-cycle windows
  assign mode = cfg_r[0][1:0];
  assign lvl  = cfg_r[0][2];
  assign bfq  = cfg_r[1][15:0];
  assign wt   = cfg_r[2][9:0];
  assign sd   = cfg_r[4][9:0];
  assign td   = cfg_r[5][9:0];
  assign slow = TICK_COUNT > 7;
  // ----------------------------------------
  // Settings mirror
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (avs_write_i && !avs_waitrequest_o && !avs_address_i[5]) begin
      cfg_r[avs_address_i[4:2]] <= avs_writedata_i;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_run_rise;   $rose(run_cmd_i);   endsequence
  sequence s_hold_brake; brake_on_o [*8];    endsequence
  sequence s_coast;      !brake_on_o [*8];   endsequence
  a_outputs_excl : assert property (!(drive_on_o && brake_on_o))
    else $error("drive and brake both on");
  a_pct_idle_zero : assert property (!brake_on_o |-> brake_pct_o == 8'h00)
    else $error("brake current while not braking");
  a_carrier_derate : assert property (carrier_derate_o == (brake_carrier_o >= CARR_DERATE)
    && brake_carrier_o >= CARR_MIN && brake_carrier_o <= CARR_MAX)
    else $error("carrier or derate flag wrong");
  a_mode_off_quiet : assert property (mode == EN_OFF && cfg_r[0][15:8] != FN_BRAKE
    |-> !brake_on_o) else $error("braking with braking off");
  a_start_brake : assert property (mode == EN_AUTO && td > 1 && !drive_on_o
    && !brake_on_o && out_freq_i == 16'h0000 ##0 s_run_rise |-> ##[1:8] brake_on_o)
    else $error("no start braking");
  a_edge_full_hold : assert property (mode == EN_AUTO && !lvl && slow && sd > 1
    && td > 1 && $rose(brake_on_o) |-> s_hold_brake) else $error("edge braking cut short");
  a_wait_coast : assert property (mode == EN_AUTO && slow && wt > 1
    && $fell(drive_on_o) |-> s_coast) else $error("braking before wait time");
  a_freq_run_only : assert property ((mode == EN_FREQ && !run_cmd_i) [*8]
    |-> !brake_on_o) else $error("frequency braking without run");
  a_freq_enter : assert property ((mode == EN_FREQ && run_cmd_i && wt == 10'h000
    && cmd_freq_i <= bfq && out_freq_i <= bfq) [*8] |-> brake_on_o)
    else $error("no braking at low frequency");
  a_freq_release : assert property ((mode == EN_FREQ && lvl && run_cmd_i
    && {1'b0, cmd_freq_i} >= bfq + 17'h000c8) [*8] |-> !brake_on_o)
    else $error("braking above release frequency");
endmodule // dbs_seq_monitor

bind dbs_sequencer dbs_seq_monitor #(.TICK_COUNT(TICK_COUNT)) u_mon (.clk_i, .sys_rst_i,
  .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .run_cmd_i,
  .cmd_freq_i, .out_freq_i, .drive_on_o, .brake_on_o, .brake_pct_o, .brake_carrier_o,
  .carrier_derate_o);

// file: verification/test_dbs_sequencer.sv
/*
  Self-checking bench of the braking sequencer with a motor model.
  Assumes a 125 MHz clock and a 10-cycle tick for simulation.
*/
module test_dbs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import dbs_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, rd = 0, wr = 0, run = 0, breq = 0;
  logic [5:0]  adr = '0;
  logic [3:0]  be = 4'hf;
  logic [31:0] wd = '0, rdat, q;
  logic [15:0] cmd = '0, outf;
  logic        wrq, drv, brk, der;
  logic [7:0]  pct, carr;
  logic [31:0] cfg_w [6] = '{32'h1f4, 32'h2, 32'h2346, 32'h3, 32'h2, 32'h28};
  int          bad_count = 0, check_count = 0, seed = 72, c;
  always #4 clk_i = ~clk_i;
  dbs_sequencer #(.TICK_COUNT(10)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
    .run_cmd_i(run), .brake_req_i(breq), .cmd_freq_i(cmd), .out_freq_i(outf),
    .drive_on_o(drv), .brake_on_o(brk), .brake_pct_o(pct), .brake_carrier_o(carr),
    .carrier_derate_o(der));
  dbs_motor_model u_motor (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .drive_on_i(drv),
    .brake_on_i(brk), .cmd_freq_i(cmd), .out_freq_o(outf));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input int w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= w != 0;
    rd <= w == 0;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    while (wrq !== 1'b0) begin
      @(posedge clk_i);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wfor(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  function automatic logic [7:0] exp_pct(input int f);
    return 8'((f > 70 ? 70 : f) * 100 / 70);
  endfunction
  function automatic logic [8:0] exp_car(input int v);
    int k;
    k = v < 5 ? 5 : (v > 120 ? 120 : v);
    return {k >= 30, 8'(k)};
  endfunction
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 1600 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    results();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1, OFS_CTRL, 32'h3);
    bus(0, OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    be <= 4'h1;
    bus(1, OFS_FORCE, 32'hffff);
    be <= 4'hf;
    bus(0, OFS_FORCE, 32'h0);
    chk(q, 32'h46);
    bus(0, 6'h20, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = (i < 6) ? (i * 29) : {$random(seed)} % 256;
      bus(1, OFS_CARR, 32'(c));
      repeat (3) @(posedge clk_i);
      chk(32'({der, carr}), 32'(exp_car(c)));
    end
    foreach (cfg_w[i]) bus(1, 6'(i * 4 + 4), cfg_w[i]);
    // Internal start and stop braking, edge then level
    for (int l = 0; l < 2; l++) begin
      bus(1, OFS_CTRL, {29'h0, 1'(l), EN_AUTO});
      run <= 1'b1;
      cmd <= 16'h0bb8;
      wfor(brk, 1'b1, 20);
      chk(32'(pct), 32'(exp_pct(35)));
      wfor(drv, 1'b1, 60);
      chk(32'(brk), 32'h0);
      repeat (40) @(posedge clk_i);
      run <= 1'b0;
      cmd <= 16'h0000;
      wfor(drv, 1'b0, 60);
      chk(32'(brk), 32'h0);
      wfor(brk, 1'b1, 40);
      chk(32'(pct), 32'(exp_pct(70)));
      @(posedge clk_i);
      run <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(32'(brk), 32'(l == 0));
      run <= 1'b0;
      repeat (150) @(posedge clk_i);
      chk(32'(drv | brk), 32'h0);
    end
    // External request, then ignored in frequency mode
    bus(1, OFS_WAIT, 32'h0);
    for (int m = 0; m < 3; m += 2) begin
      bus(1, OFS_CTRL, 32'h0704 | m);
      breq <= 1'b1;
      wfor(brk, 1'b1, 20);
      chk(32'(brk), 32'(m == 0));
      if (m == 0) chk(32'(pct), 32'(exp_pct(70)));
      @(posedge clk_i);
      breq <= 1'b0;
      wfor(brk, 1'b0, 20);
      chk(32'(brk), 32'h0);
    end
    // Frequency mode with random commands, edge then level
    bus(1, OFS_BFREQ, 32'h3e8);
    for (int l = 0; l < 2; l++) begin
      bus(1, OFS_CTRL, {29'h0, 1'(l), EN_FREQ});
      run <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        c = (i == 0) ? 1500 * l : {$random(seed)} % 1600;
        cmd <= 16'(c);
        repeat (50) @(posedge clk_i);
        if (c <= 1000) chk(32'(brk), 32'h1);
        if (c >= 1200) chk(32'(drv & !brk), 32'h1);
      end
      run <= 1'b0;
      cmd <= 16'h0000;
      repeat (50) @(posedge clk_i);
      chk(32'(brk), 32'h0);
    end
    results();
  end
endmodule // test_dbs_sequencer
